/* File: rtl/rng_pkg.sv */
package rng_pkg;
    // Register offsets within the block (HADDR[3:0])
    localparam logic [3:0]  OFF_CONFIG   = 4'h0;
    localparam logic [3:0]  OFF_STATUS   = 4'h4;
    localparam logic [3:0]  OFF_VALUE    = 4'h8;
    localparam int          ADDR_W       = 4;
    // Field positions
    localparam int          CFG_OFF_BIT  = 2;
    localparam int          STAT_RDY_BIT = 0;
    localparam int          VALUE_W      = 16;
    // Reset values
    localparam logic [31:0] CONFIG_RST   = 32'h0000_0000;
    localparam logic [15:0] VALUE_RST    = 16'h0000;
    localparam logic [15:0] LFSR_SEED    = 16'hACE1;
    // AHB encodings
    localparam logic [2:0]  SIZE_WORD    = 3'h2;
    // Timing
    localparam int          CLK_PERIOD_PS  = 8000;
    localparam int          SAMPLE_TIME_PS = 1250000;
    localparam int          SAMPLE_CYCLES  =
        (SAMPLE_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int          CNT_W        = 8;
endpackage

/* File: rtl/noise_sampler.sv */
`timescale 1ns/100ps
module noise_sampler (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Control
    input  wire logic        run,
    // Analogue noise bit
    input  wire logic        noiseBit,
    // New value
    output logic             samplePulse,
    output logic [15:0]      sampleValue
);
    localparam logic [rng_pkg::CNT_W-1:0] LAST =
        rng_pkg::CNT_W'(rng_pkg::SAMPLE_CYCLES - 1);

    logic                     noiseMeta;
    logic                     noiseSync;
    logic [15:0]              lfsr;
    logic [rng_pkg::CNT_W-1:0] count;
    logic                     countDone;
    logic                     feedback;

    assign countDone = (count == LAST);
    assign feedback  = lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10] ^ noiseSync;

    always_ff @(posedge clk) begin
        noiseMeta <= noiseBit;
        noiseSync <= noiseMeta;
    end

    // Noise keeps stirring the register; one value per sample period
    always_ff @(posedge clk) begin
        if (!rst_n || !run) begin
            count       <= '0;
            samplePulse <= 1'b0;
        end else begin
            count       <= countDone ? '0 : count + 1'b1;
            samplePulse <= countDone;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            lfsr        <= rng_pkg::LFSR_SEED;
            sampleValue <= rng_pkg::VALUE_RST;
        end else begin
            if (run) begin
                lfsr <= {lfsr[14:0], feedback};
            end
            if (run && countDone) begin
                sampleValue <= lfsr;
            end
        end
    end

    // Helper: cycles since last pulse
    logic [rng_pkg::CNT_W:0] gap;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            gap <= '1;
        end else if (samplePulse) begin
            gap <= '0;
        end else if (gap != '1) begin
            gap <= gap + 1'b1;
        end
    end

    sample_gap_a: assert property (@(posedge clk) disable iff (!rst_n)
        samplePulse |-> gap >= (rng_pkg::CNT_W+1)'(rng_pkg::SAMPLE_CYCLES - 1))
        else $error("Random values produced too close together");

    sample_load_a: assert property (@(posedge clk) disable iff (!rst_n)
        samplePulse |-> sampleValue == $past(lfsr))
        else $error("Sample value not taken from the noise register");
endmodule

/* File: rtl/random_number_generator_port.sv */
`timescale 1ns/100ps
// Contract
// - Each value read returns fresh 16-bit number
// - Non-word accesses get error response
// - Values at least 1.25 us apart
// - Config bit 2 powers down and gates
// - Value read waits until number ready
// - Status bit 0 shows valid value
// - Status valid held zero while disabled
// - Value in 15:0, upper bits zero
// - Config 0x00, status 0x04, value 0x08
// - Value reads need no arbitration
module random_number_generator_port (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // AHB-Lite slave
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic [31:0]      HRDATA,
    output logic             HREADYOUT,
    output logic             HRESP,
    // Analogue noise source
    input  wire logic        noiseBit,
    output logic             oscPowerDown,
    output logic             genClkEnable
);
    typedef enum logic [2:0] {
        PH_IDLE, PH_WRITE, PH_DONE, PH_VALWAIT, PH_ERR1, PH_ERR2
    } phase_e;

    phase_e                    phase;
    phase_e                    next_phase;
    logic                      generatorOff;
    logic                      valid;
    logic [15:0]               heldValue;
    logic [rng_pkg::ADDR_W-1:0] wrOffset;
    logic                      samplePulse;
    logic [15:0]               sampleValue;

    // Address phase decode
    logic                      addrAccept;
    logic                      sizeBad;
    logic [rng_pkg::ADDR_W-1:0] offset;
    logic                      hitConfig;
    logic                      hitStatus;
    logic                      hitValue;
    logic                      readValue;
    logic                      readReady;
    logic                      waitDone;
    logic                      consume;
    logic [31:0]               statusWord;
    logic [31:0]               readWord;

    assign addrAccept = HSEL && HTRANS[1] && HREADY;
    assign sizeBad    = HSIZE != rng_pkg::SIZE_WORD;
    assign offset     = HADDR[rng_pkg::ADDR_W-1:0];
    assign hitConfig  = offset == rng_pkg::OFF_CONFIG;
    assign hitStatus  = offset == rng_pkg::OFF_STATUS;
    assign hitValue   = offset == rng_pkg::OFF_VALUE;
    // No lock or arbitration on value reads
    assign readValue  = addrAccept && !sizeBad && !HWRITE && hitValue;
    assign readReady  = readValue && valid;
    assign waitDone   = (phase == PH_VALWAIT) && valid;
    assign consume    = readReady || waitDone;
    assign statusWord = {31'h0000_0000, valid && !generatorOff};
    assign readWord   = hitConfig ? {29'h0000_0000, generatorOff, 2'h0} :
                        hitStatus ? statusWord :
                        hitValue  ? {16'h0000, heldValue} : 32'h0000_0000;

    assign HREADYOUT    = (phase != PH_VALWAIT) && (phase != PH_ERR1);
    assign HRESP        = (phase == PH_ERR1) || (phase == PH_ERR2);
    assign oscPowerDown = generatorOff;
    assign genClkEnable = !generatorOff;

    always_comb begin
        next_phase = phase;
        case (phase)
            PH_VALWAIT: next_phase = valid ? PH_DONE : PH_VALWAIT;
            PH_ERR1:    next_phase = PH_ERR2;
            default: begin
                if (!addrAccept) begin
                    next_phase = PH_IDLE;
                end else if (sizeBad) begin
                    next_phase = PH_ERR1;
                end else if (HWRITE) begin
                    next_phase = PH_WRITE;
                end else if (hitValue && !valid) begin
                    next_phase = PH_VALWAIT;
                end else begin
                    next_phase = PH_DONE;
                end
            end
        endcase
    end

    noise_sampler sampler (
        .clk         (clk),
        .rst_n       (rst_n),
        .run         (!generatorOff),
        .noiseBit    (noiseBit),
        .samplePulse (samplePulse),
        .sampleValue (sampleValue)
    );

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            phase    <= PH_IDLE;
            wrOffset <= rng_pkg::OFF_CONFIG;
        end else begin
            phase <= next_phase;
            if (addrAccept) begin
                wrOffset <= offset;
            end
        end
    end

    // Only the disable bit is stored; reserved config bits read as zero
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            generatorOff <= rng_pkg::CONFIG_RST[rng_pkg::CFG_OFF_BIT];
        end else if (phase == PH_WRITE && wrOffset == rng_pkg::OFF_CONFIG) begin
            generatorOff <= HWDATA[rng_pkg::CFG_OFF_BIT];
        end
    end

    // New sample wins over a consuming read in the same cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            valid     <= 1'b0;
            heldValue <= rng_pkg::VALUE_RST;
        end else if (generatorOff) begin
            valid <= 1'b0;
        end else if (samplePulse) begin
            valid     <= 1'b1;
            heldValue <= sampleValue;
        end else if (consume) begin
            valid <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            HRDATA <= 32'h0000_0000;
        end else if (waitDone) begin
            HRDATA <= {16'h0000, heldValue};
        end else if (addrAccept && !HWRITE && !sizeBad) begin
            HRDATA <= readWord;
        end
    end

    size_err_a: assert property (@(posedge clk) disable iff (!rst_n)
        addrAccept && sizeBad |=> (!HREADYOUT && HRESP) ##1 (HREADYOUT && HRESP))
        else $error("Narrow access did not get a two-cycle error");

    cfg_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        phase == PH_WRITE && wrOffset == rng_pkg::OFF_CONFIG
        |=> generatorOff == $past(HWDATA[rng_pkg::CFG_OFF_BIT])
            && genClkEnable == !generatorOff)
        else $error("Disable bit not taken from config write");

    wait_done_a: assert property (@(posedge clk) disable iff (!rst_n)
        phase == PH_VALWAIT && valid |=> HREADYOUT && HRDATA[15:0] == $past(heldValue))
        else $error("Waiting value read did not complete with the value");

    wait_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        readValue && !valid && !samplePulse |=> !HREADYOUT)
        else $error("Value read without a number was not stalled");

    status_map_a: assert property (@(posedge clk) disable iff (!rst_n)
        addrAccept && !HWRITE && !sizeBad && hitStatus
        |=> HRDATA == {31'h0000_0000, $past(valid && !generatorOff)})
        else $error("Status word does not match valid flag");

    off_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
        generatorOff |=> !valid)
        else $error("Valid flag set while generator disabled");

    value_upper_a: assert property (@(posedge clk) disable iff (!rst_n)
        phase == PH_DONE && $past(hitValue) |-> HRDATA[31:16] == 16'h0000)
        else $error("Upper value bits not zero");

    consume_clr_a: assert property (@(posedge clk) disable iff (!rst_n)
        consume && !samplePulse |=> !valid)
        else $error("Completed value read did not clear valid");

    sample_set_a: assert property (@(posedge clk) disable iff (!rst_n)
        samplePulse && !generatorOff |=> valid && heldValue == $past(sampleValue))
        else $error("Fresh sample not made valid");

    narrow_nowrite_a: assert property (@(posedge clk) disable iff (!rst_n)
        addrAccept && sizeBad |=> ##1 $stable(generatorOff))
        else $error("Narrow access changed the configuration");

    read_okay_a: assert property (@(posedge clk) disable iff (!rst_n)
        addrAccept && !sizeBad |=> !HRESP)
        else $error("Word access answered with an error");

    config_read_a: assert property (@(posedge clk) disable iff (!rst_n)
        addrAccept && !HWRITE && !sizeBad && hitConfig
        |=> HRDATA == (32'($past(generatorOff)) << rng_pkg::CFG_OFF_BIT))
        else $error("Config read does not show the disable bit");

    value_read_a: assert property (@(posedge clk) disable iff (!rst_n)
        readReady |=> HREADYOUT && HRDATA == {16'h0000, $past(heldValue)})
        else $error("Ready value read did not return the held number");

    unmapped_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
        addrAccept && !HWRITE && !sizeBad && !hitConfig && !hitStatus && !hitValue
        |=> HRDATA == 32'h0000_0000 && !HRESP)
        else $error("Unmapped read did not return zero");

    status_off_a: assert property (@(posedge clk) disable iff (!rst_n)
        addrAccept && !HWRITE && !sizeBad && hitStatus && generatorOff
        |=> HRDATA == 32'h0000_0000)
        else $error("Status shows a value while disabled");

    // Stall ends within one sample period while the generator runs
    wait_bound_a: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(phase == PH_VALWAIT) && !generatorOff |-> ##[1:170] phase != PH_VALWAIT)
        else $error("Value read stalled too long while enabled");
endmodule

/* File: tb/ahb_host.sv */
`timescale 1ns/100ps
module ahb_host (
    // Clock
    input  wire logic        clk,
    // Bus request
    output logic             HSEL,
    output logic [31:0]      HADDR,
    output logic [1:0]       HTRANS,
    output logic             HWRITE,
    output logic [2:0]       HSIZE,
    output logic [31:0]      HWDATA,
    // Bus answer
    input  wire logic [31:0] HRDATA,
    input  wire logic        HREADYOUT,
    input  wire logic        HRESP
);
    initial begin
        HSEL   = 1'b0;
        HADDR  = 32'h0000_0000;
        HTRANS = 2'h0;
        HWRITE = 1'b0;
        HSIZE  = 3'h2;
        HWDATA = 32'h0000_0000;
    end

    // Word size unless a refusal is wanted; reserved bits come from caller as zero
    task automatic xfer(input logic wr, input logic [31:0] addr, input logic [2:0] size,
                        input logic [31:0] wdata, output logic [31:0] rdata,
                        output logic resp, output int waits);
        waits = 0;
        @(posedge clk);
        HSEL   <= 1'b1;
        HADDR  <= addr;
        HTRANS <= 2'h2;
        HWRITE <= wr;
        HSIZE  <= size;
        @(posedge clk);
        // Released address shows inverse of last value; HSEL and HTRANS drop to zero
        HSEL   <= 1'b0;
        HTRANS <= 2'h0;
        HADDR  <= ~addr;
        HWDATA <= wdata;
        do begin
            @(posedge clk);
            waits++;
        end while (HREADYOUT !== 1'b1 && waits < 2000);
        rdata = HRDATA;
        resp  = HRESP;
        HWDATA <= ~wdata;
    endtask
endmodule

/* File: tb/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
    logic        clk;
    logic        rst_n;
    logic        noiseBit = 1'b0;
    logic        HSEL;
    logic [31:0] HADDR;
    logic [1:0]  HTRANS;
    logic        HWRITE;
    logic [2:0]  HSIZE;
    logic [31:0] HWDATA;
    logic [31:0] HRDATA;
    logic        HREADYOUT;
    logic        HRESP;
    logic        oscPowerDown;
    logic        genClkEnable;
    logic [31:0] d;
    logic        r;
    logic [15:0] v1;
    int          w;
    int          num_errors;
    int          n_tests;

    random_number_generator_port random_number_generator_port_inst (
        .clk(clk), .rst_n(rst_n), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
        .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT),
        .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .noiseBit(noiseBit),
        .oscPowerDown(oscPowerDown), .genClkEnable(genClkEnable));

    ahb_host ahb_host_inst (
        .clk(clk), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
        .HSIZE(HSIZE), .HWDATA(HWDATA), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
        .HRESP(HRESP));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Irregular noise pattern
    always @(posedge clk) begin
        noiseBit <= ~noiseBit ^ HADDR[0] ^ (n_tests[1:0] == 2'h1);
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            num_errors++;
        end
    endtask

    task automatic rd(input logic [31:0] addr, input logic [2:0] size);
        ahb_host_inst.xfer(1'b0, addr, size, 32'h0000_0000, d, r, w);
        chk({31'h0, w < 2000}, 32'h0000_0001);
    endtask

    task automatic wr(input logic [31:0] addr, input logic [2:0] size, input logic [31:0] v);
        ahb_host_inst.xfer(1'b1, addr, size, v, d, r, w);
        chk({31'h0, w < 2000}, 32'h0000_0001);
    endtask

    task automatic wrap_up;
        if (num_errors == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        wrap_up();
    end

    initial begin
        rst_n      = 1'b0;
        num_errors = 0;
        n_tests    = 0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        rd(32'h0000_0000, 3'h2);
        chk(d, 32'h0000_0000);
        rd(32'h0000_0004, 3'h2);
        chk(d, 32'h0000_0000);
        // Value read before first sample stalls
        rd(32'h0000_0008, 3'h2);
        chk({31'h0, w > 100}, 32'h0000_0001);
        chk({d[31:16], 15'h0, r}, 32'h0000_0000);
        v1 = d[15:0];
        rd(32'h0000_0004, 3'h2);
        chk(d, 32'h0000_0000);
        rd(32'h0000_0008, 3'h2);
        chk({31'h0, w >= 150 && w <= 162}, 32'h0000_0001);
        chk({31'h0, d[15:0] != v1}, 32'h0000_0001);
        repeat (170) @(posedge clk);
        rd(32'h0000_0004, 3'h2);
        chk(d, 32'h0000_0001);
        rd(32'h0000_0008, 3'h2);
        chk(w, 1);
        // Narrow accesses refused, no write
        rd(32'h0000_0008, 3'h0);
        chk({31'h0, r}, 32'h0000_0001);
        wr(32'h0000_0000, 3'h1, 32'h0000_0004);
        chk({31'h0, r}, 32'h0000_0001);
        rd(32'h0000_0000, 3'h2);
        chk(d, 32'h0000_0000);
        wr(32'h0000_0000, 3'h2, 32'h0000_0004);
        repeat (2) @(posedge clk);
        chk({30'h0, oscPowerDown, genClkEnable}, 32'h0000_0002);
        rd(32'h0000_0000, 3'h2);
        chk(d, 32'h0000_0004);
        repeat (200) @(posedge clk);
        rd(32'h0000_0004, 3'h2);
        chk(d, 32'h0000_0000);
        wr(32'h0000_0000, 3'h2, 32'h0000_0000);
        rd(32'h0000_000C, 3'h2);
        chk(d | {31'h0, r}, 32'h0000_0000);
        rd(32'h0000_0008, 3'h2);
        chk({31'h0, w > 100 && w <= 162}, 32'h0000_0001);
        wrap_up();
    end
endmodule
